/* File: verilog/uic_pkg.sv */
// package: constants, register map and status layout for the unit index and clock source block
package uic_pkg;

   // register port geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int IDX_W  = 4;
   localparam int NUM_UNITS = 16;

   // address: upper nibble selects the instance, lower nibble the register
   localparam int INST_MSB = 7;
   localparam int INST_LSB = 4;
   localparam int OFFS_MSB = 3;

   // register offsets (low nibble)
   localparam logic [3:0] OFF_CTRL       = 4'h0;
   localparam logic [3:0] OFF_PHASE_RATE = 4'h1;
   localparam logic [3:0] OFF_SERVO_DIV  = 4'h2;
   localparam logic [3:0] OFF_PHASE_DIV  = 4'h3;
   localparam logic [3:0] OFF_PHASE_MULT = 4'h4;
   localparam logic [3:0] OFF_STATUS     = 4'h5;
   localparam logic [3:0] OFF_IRQ_STAT   = 4'h6;
   localparam logic [3:0] OFF_IRQ_MASK   = 4'h7;

   // control register fields
   localparam int CTRL_OVR_EN_BIT = 4;
   localparam int CTRL_OVR_IDX_LSB = 0;

   // interrupt status/mask bit positions
   localparam int IRQ_DUP_BIT     = 0;
   localparam int IRQ_NOCLK_BIT   = 1;
   localparam int IRQ_SRC_CHG_BIT = 2;
   localparam int IRQ_W           = 3;

   // status encodings
   localparam logic [3:0] CFG_ERR_NONE = 4'h0;
   localparam logic [3:0] CFG_ERR_DUP  = 4'h7;

   // reset values and minimum phase rate
   localparam logic [4:0]  RST_CTRL       = 5'h00;
   localparam logic [15:0] RST_PHASE_RATE = 16'h0fa0;
   localparam logic [7:0]  RST_SERVO_DIV  = 8'h00;
   localparam logic [7:0]  RST_PHASE_DIV  = 8'h00;
   localparam logic [7:0]  RST_PHASE_MULT = 8'h00;
   localparam logic [15:0] MIN_PHASE_RATE = 16'h0002;

   // timing: distributed phase clock must be seen within this time
   localparam int CLK_MHZ          = 40;
   localparam int NOCLK_TIMEOUT_US = 100;
   localparam int NOCLK_CYCLES     = NOCLK_TIMEOUT_US * CLK_MHZ;
   localparam int WD_W             = 13;

   // cycles after reset release before the switch is latched (synchroniser settle)
   localparam logic [1:0] STRAP_SETTLE = 2'h3;

   // status word carried to the read mux
   typedef struct packed {
      logic [3:0] cfg_err;
      logic       missing_clk;
      logic       is_source;
      logic       align_warn;
      logic [3:0] src_idx;
      logic [3:0] own_idx;
   } uic_status_t;

   // register write request
   typedef struct packed {
      logic [3:0]        offs;
      logic [DATA_W-1:0] data;
   } uic_wreq_t;

endpackage

/* File: verilog/uic_unit_clock.sv */
// unit index selection, duplicate detection and servo/phase clock source control
//
// Overview of operation
// [RULE1] The unit index is the sixteen-position switch value, 0 to F mapping to 0 to 15, 0 by default.
// [RULE2] Register accesses are answered only when the instance field of the address equals the unit index.
// [RULE3] When another unit claims the same index, the configuration error code in the status word reads 7.
// [RULE4] One unit drives servo and phase clocks to all others; the rest follow the distributed clocks.
// [RULE5] By default the unit with the lowest claimed index is the clock source.
// [RULE6] A register setting can name any index as clock source, overriding the lowest-index default.
// [RULE7] The host places the clock-source unit, and by default the lowest-index unit, on the CPU rack.
// [RULE8] If the clock source cannot be seen by the CPU because it is on an expansion rack, the missing-clock flag is 1.
// [RULE9] The host programs phase rate and servo divider equal to those of the clock-source unit.
// [RULE10] The host sets the phase divider and multiplier to 0 here and in the source unit.
// [RULE11] The switch index is sampled once after reset and held until the next reset.
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/100ps
module uic_unit_clock
   import uic_pkg::*;
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // pins: switch, rack strap, peer index claims
   input  wire logic [IDX_W-1:0]  index_switch,
   input  wire logic              on_cpu_rack,
   input  wire logic [15:0]       peer_index_claim,
   // distributed clock pins (open to all units)
   input  wire logic              servo_clk_in,
   input  wire logic              phase_clk_in,
   output logic                   servo_clk_out,
   output logic                   servo_clk_oe,
   output logic                   phase_clk_out,
   output logic                   phase_clk_oe,
   // own index claim driven onto the backplane
   output logic [IDX_W-1:0]       io_asic_instance,
   // ticks for the encoder logic
   output logic                   phase_tick,
   output logic                   servo_tick,
   // register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [DATA_W-1:0]      reg_rdata,
   // interrupt
   output logic                   irq
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [IDX_W-1:0] sw_meta_ff,  sw_sync_ff;
   logic             rack_meta_ff, rack_sync_ff;
   logic [15:0]      peer_meta_ff, peer_sync_ff;
   logic             servo_meta_ff, servo_sync_ff, servo_prev_ff;
   logic             phase_meta_ff, phase_sync_ff, phase_prev_ff;

   always_ff @(posedge mclk) begin
      if (rst) begin
         sw_meta_ff    <= 4'h0;
         sw_sync_ff    <= 4'h0;
         rack_meta_ff  <= 1'b0;
         rack_sync_ff  <= 1'b0;
         peer_meta_ff  <= 16'h0000;
         peer_sync_ff  <= 16'h0000;
         servo_meta_ff <= 1'b0;
         servo_sync_ff <= 1'b0;
         servo_prev_ff <= 1'b0;
         phase_meta_ff <= 1'b0;
         phase_sync_ff <= 1'b0;
         phase_prev_ff <= 1'b0;
      end else begin
         sw_meta_ff    <= index_switch;
         sw_sync_ff    <= sw_meta_ff;
         rack_meta_ff  <= on_cpu_rack;
         rack_sync_ff  <= rack_meta_ff;
         peer_meta_ff  <= peer_index_claim;
         peer_sync_ff  <= peer_meta_ff;
         servo_meta_ff <= servo_clk_in;
         servo_sync_ff <= servo_meta_ff;
         servo_prev_ff <= servo_sync_ff;
         phase_meta_ff <= phase_clk_in;
         phase_sync_ff <= phase_meta_ff;
         phase_prev_ff <= phase_sync_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // switch capture: taken once after the synchroniser has settled

   logic [1:0]       settle_ff;
   logic             latched_ff;
   logic [IDX_W-1:0] own_idx_ff;
   logic             cpu_rack_ff;

   always_ff @(posedge mclk) begin
      if (rst) begin
         settle_ff   <= 2'h0;
         latched_ff  <= 1'b0;
         own_idx_ff  <= 4'h0;                        // [RULE1]
         cpu_rack_ff <= 1'b0;
      end else if (!latched_ff) begin
         if (settle_ff == STRAP_SETTLE) begin
            latched_ff  <= 1'b1;
            own_idx_ff  <= sw_sync_ff;               // [RULE1] [RULE11]
            cpu_rack_ff <= rack_sync_ff;
         end else begin
            settle_ff <= settle_ff + 2'h1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         io_asic_instance <= 4'h0;
      end else begin
         io_asic_instance <= own_idx_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers

   logic [4:0]  ctrl_ff;
   logic [15:0] phase_rate_setting_ff;
   logic [7:0]  servo_rate_divider_ff;
   logic [7:0]  phase_rate_divider_ff;
   logic [7:0]  phase_rate_multiplier_ff;
   logic [IRQ_W-1:0] irq_mask_ff;

   logic      sel;
   uic_wreq_t wreq;

   // a unit ignores accesses while its index is not yet known
   assign sel       = latched_ff && (reg_addr[INST_MSB:INST_LSB] == own_idx_ff); // [RULE2]
   assign wreq      = {reg_addr[OFFS_MSB:0], reg_wdata};

   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_ff                  <= RST_CTRL;
         phase_rate_setting_ff    <= RST_PHASE_RATE;
         servo_rate_divider_ff    <= RST_SERVO_DIV;
         phase_rate_divider_ff    <= RST_PHASE_DIV;
         phase_rate_multiplier_ff <= RST_PHASE_MULT;
         irq_mask_ff              <= 3'h0;
      end else if (reg_wr && sel) begin              // [RULE2]
         case (wreq.offs)
            OFF_CTRL:       ctrl_ff                  <= wreq.data[4:0]; // [RULE6]
            OFF_PHASE_RATE: phase_rate_setting_ff    <= wreq.data[15:0];
            OFF_SERVO_DIV:  servo_rate_divider_ff    <= wreq.data[7:0];
            OFF_PHASE_DIV:  phase_rate_divider_ff    <= wreq.data[7:0];
            OFF_PHASE_MULT: phase_rate_multiplier_ff <= wreq.data[7:0];
            OFF_IRQ_MASK:   irq_mask_ff              <= wreq.data[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // index map: duplicates and default clock source

   logic [15:0]      claim_map;
   logic [IDX_W-1:0] lowest_idx;
   logic             dup_ff;
   logic [IDX_W-1:0] src_idx_ff;
   logic             is_source_ff;

   // own claim plus every peer claim seen on the backplane
   assign claim_map = peer_sync_ff | (16'h0001 << own_idx_ff);

   always_comb begin
      lowest_idx = 4'hf;
      for (int i = NUM_UNITS - 1; i >= 0; i--) begin
         if (claim_map[i]) begin
            lowest_idx = i[IDX_W-1:0];               // [RULE5]
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         dup_ff       <= 1'b0;
         src_idx_ff   <= 4'h0;
         is_source_ff <= 1'b0;
      end else if (latched_ff) begin
         dup_ff <= peer_sync_ff[own_idx_ff];         // [RULE3]
         if (ctrl_ff[CTRL_OVR_EN_BIT]) begin
            src_idx_ff   <= ctrl_ff[CTRL_OVR_IDX_LSB +: IDX_W];           // [RULE6]
            is_source_ff <= ctrl_ff[CTRL_OVR_IDX_LSB +: IDX_W] == own_idx_ff; // [RULE6]
         end else begin
            src_idx_ff   <= lowest_idx;              // [RULE5]
            is_source_ff <= lowest_idx == own_idx_ff; // [RULE5]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // local clock generation: phase period in mclk cycles, servo every n+1 phases

   logic [15:0] phase_cnt_ff;
   logic [7:0]  servo_cnt_ff;
   logic [15:0] phase_period;
   logic        gen_phase_start;

   // very short periods would leave no high or low half on the pin
   assign phase_period    = (phase_rate_setting_ff < MIN_PHASE_RATE) ? MIN_PHASE_RATE
                                                                     : phase_rate_setting_ff;
   assign gen_phase_start = is_source_ff && (phase_cnt_ff == 16'h0000);

   always_ff @(posedge mclk) begin
      if (rst || !is_source_ff) begin
         phase_cnt_ff <= 16'h0000;
         servo_cnt_ff <= 8'h00;
      end else begin
         if (phase_cnt_ff >= phase_period - 16'h0001) begin
            phase_cnt_ff <= 16'h0000;
         end else begin
            phase_cnt_ff <= phase_cnt_ff + 16'h0001;
         end
         if (gen_phase_start) begin
            if (servo_cnt_ff >= servo_rate_divider_ff) begin
               servo_cnt_ff <= 8'h00;
            end else begin
               servo_cnt_ff <= servo_cnt_ff + 8'h01;
            end
         end
      end
   end

   // only the source unit enables its pin drivers; all others listen
   always_ff @(posedge mclk) begin
      if (rst) begin
         phase_clk_out <= 1'b0;
         servo_clk_out <= 1'b0;
         phase_clk_oe  <= 1'b0;
         servo_clk_oe  <= 1'b0;
      end else begin
         phase_clk_oe  <= is_source_ff;              // [RULE4]
         servo_clk_oe  <= is_source_ff;              // [RULE4]
         phase_clk_out <= is_source_ff && (phase_cnt_ff < (phase_period >> 1));
         servo_clk_out <= is_source_ff && (servo_cnt_ff == 8'h00);
      end
   end

   // every unit, the source included, times itself off the distributed clock
   always_ff @(posedge mclk) begin
      if (rst) begin
         phase_tick <= 1'b0;
         servo_tick <= 1'b0;
      end else begin
         phase_tick <= phase_sync_ff && !phase_prev_ff; // [RULE4]
         servo_tick <= servo_sync_ff && !servo_prev_ff; // [RULE4]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // missing-clock detection

   logic [WD_W-1:0] wd_cnt_ff;
   logic            missing_clock_flag_ff;
   logic            wd_expired;

   // a gap of exactly the timeout is still legal, so a phase period equal to it never flags
   assign wd_expired = wd_cnt_ff == WD_W'(NOCLK_CYCLES);

   always_ff @(posedge mclk) begin
      if (rst || !latched_ff || (phase_sync_ff && !phase_prev_ff)) begin
         wd_cnt_ff <= '0;
      end else if (!wd_expired) begin
         wd_cnt_ff <= wd_cnt_ff + WD_W'(1);
      end
   end

   // a source off the cpu rack is never seen by the cpu, so flag it at once
   always_ff @(posedge mclk) begin
      if (rst) begin
         missing_clock_flag_ff <= 1'b0;
      end else begin
         missing_clock_flag_ff <= latched_ff && ((is_source_ff && !cpu_rack_ff) || wd_expired); // [RULE8]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status word and interrupts

   uic_status_t status;
   logic [IRQ_W-1:0] irq_stat_ff;
   logic [IRQ_W-1:0] irq_evt;
   logic             dup_prev_ff, miss_prev_ff;
   logic [IDX_W-1:0] src_prev_ff;
   logic             stat_rd;

   always_comb begin
      status.cfg_err     = dup_ff ? CFG_ERR_DUP : CFG_ERR_NONE; // [RULE3]
      status.missing_clk = missing_clock_flag_ff;              // [RULE8]
      status.is_source   = is_source_ff;
      status.align_warn  = (phase_rate_divider_ff != 8'h00) || (phase_rate_multiplier_ff != 8'h00);
      status.src_idx     = src_idx_ff;
      status.own_idx     = own_idx_ff;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         dup_prev_ff  <= 1'b0;
         miss_prev_ff <= 1'b0;
         src_prev_ff  <= 4'h0;
      end else begin
         dup_prev_ff  <= dup_ff;
         miss_prev_ff <= missing_clock_flag_ff;
         src_prev_ff  <= src_idx_ff;
      end
   end

   assign irq_evt[IRQ_DUP_BIT]     = dup_ff && !dup_prev_ff;
   assign irq_evt[IRQ_NOCLK_BIT]   = missing_clock_flag_ff && !miss_prev_ff;
   assign irq_evt[IRQ_SRC_CHG_BIT] = src_idx_ff != src_prev_ff;
   assign stat_rd                  = reg_rd && sel && (wreq.offs == OFF_IRQ_STAT);

   // read clears, but an event in the same cycle survives
   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_stat_ff <= 3'h0;
      end else begin
         irq_stat_ff <= (stat_rd ? 3'h0 : irq_stat_ff) | irq_evt;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((stat_rd ? 3'h0 : irq_stat_ff) | irq_evt) & irq_mask_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data, one cycle after the strobe; zero when not addressed

   always_ff @(posedge mclk) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd && sel) begin              // [RULE2]
         case (wreq.offs)
            OFF_CTRL:       reg_rdata <= {27'h0, ctrl_ff};
            OFF_PHASE_RATE: reg_rdata <= {16'h0, phase_rate_setting_ff};
            OFF_SERVO_DIV:  reg_rdata <= {24'h0, servo_rate_divider_ff};
            OFF_PHASE_DIV:  reg_rdata <= {24'h0, phase_rate_divider_ff};
            OFF_PHASE_MULT: reg_rdata <= {24'h0, phase_rate_multiplier_ff};
            OFF_STATUS:     reg_rdata <= {17'h0, status};
            OFF_IRQ_STAT:   reg_rdata <= {29'h0, irq_stat_ff};
            OFF_IRQ_MASK:   reg_rdata <= {29'h0, irq_mask_ff};
            default:        reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

endmodule

/* File: tb/uic_unit_clock_checker.sv */
// checker: register answers, status word and clock drive of the unit clock block
`timescale 1ns/100ps
module uic_unit_clock_checker
   import uic_pkg::*;
(
   // clock and reset
   input wire logic              mclk,
   input wire logic              rst,
   // pins
   input wire logic [IDX_W-1:0]  index_switch,
   input wire logic              on_cpu_rack,
   input wire logic [15:0]       peer_index_claim,
   input wire logic              servo_clk_in,
   input wire logic              phase_clk_in,
   input wire logic              servo_clk_out,
   input wire logic              servo_clk_oe,
   input wire logic              phase_clk_out,
   input wire logic              phase_clk_oe,
   input wire logic [IDX_W-1:0]  io_asic_instance,
   input wire logic              phase_tick,
   input wire logic              servo_tick,
   // register port and interrupt
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic              irq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [3:0] lo(input logic [15:0] v);
      lo = 4'h0;
      for (int i = 15; i >= 0; i--) if (v[i]) lo = 4'(i);
   endfunction
   logic [3:0] live_cnt_ff;
   logic       ovr_en_ff;
   logic [3:0] ovr_idx_ff;
   // status checks only once the switch latch and selection have settled
   wire        live    = live_cnt_ff == 4'hf;
   wire [15:0] claims  = peer_index_claim | (16'h1 << io_asic_instance);
   wire [3:0]  exp_src = ovr_en_ff ? ovr_idx_ff : lo(claims);
   wire        st_rd   = reg_rd && live && reg_addr == {io_asic_instance, OFF_STATUS};
   always_ff @(posedge mclk) begin
      if (rst) live_cnt_ff <= 4'h0;
      else if (!live) live_cnt_ff <= live_cnt_ff + 4'h1;
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         ovr_en_ff  <= 1'b0;
         ovr_idx_ff <= 4'h0;
      end else if (reg_wr && live && reg_addr == {io_asic_instance, OFF_CTRL}) begin
         ovr_en_ff  <= reg_wdata[CTRL_OVR_EN_BIT];
         ovr_idx_ff <= reg_wdata[3:0];
      end
   end
   sequence s_calm;
      ($stable(peer_index_claim) && $stable(exp_src))[*6] ##0 st_rd;
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   property p_own_idx;
      st_rd |=> reg_rdata[3:0] == $past(io_asic_instance);
   endproperty
   a_own_idx: assert property (p_own_idx) else $error("own index field wrong");
   property p_dup;
      s_calm |=> reg_rdata[14:11] == ($past(peer_index_claim[io_asic_instance]) ? CFG_ERR_DUP : CFG_ERR_NONE);
   endproperty
   a_dup: assert property (p_dup) else $error("config error code wrong");
   property p_src;
      s_calm |=> reg_rdata[7:4] == $past(exp_src) && reg_rdata[9] == ($past(exp_src) == io_asic_instance);
   endproperty
   a_src: assert property (p_src) else $error("clock source choice wrong");
   property p_src_oe;
      s_calm |=> reg_rdata[9] == phase_clk_oe;
   endproperty
   a_src_oe: assert property (p_src_oe) else $error("drive enable disagrees with source flag");
   property p_missing;
      s_calm |=> reg_rdata[10] == (reg_rdata[9] && !on_cpu_rack);
   endproperty
   a_missing: assert property (p_missing) else $error("missing clock flag wrong");
   property p_oe_pair;
      phase_clk_oe == servo_clk_oe;
   endproperty
   a_oe_pair: assert property (p_oe_pair) else $error("servo and phase drive split");
   property p_idle_zero;
      !$past(reg_rd) |-> reg_rdata == 32'h0;
   endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("read data without read");
   property p_other_inst;
      reg_rd && reg_addr[7:4] != io_asic_instance |=> reg_rdata == 32'h0;
   endproperty
   a_other_inst: assert property (p_other_inst) else $error("answered foreign instance");
   property p_unmapped;
      reg_rd && reg_addr[3] |=> reg_rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped offset not zero");
   property p_tick;
      $rose(phase_clk_in) |-> ##[2:4] phase_tick;
   endproperty
   a_tick: assert property (p_tick) else $error("no tick after distributed phase edge");
endmodule
bind uic_unit_clock uic_unit_clock_checker u_chk (.mclk, .rst, .index_switch, .on_cpu_rack, .peer_index_claim,
   .servo_clk_in, .phase_clk_in, .servo_clk_out, .servo_clk_oe, .phase_clk_out, .phase_clk_oe, .io_asic_instance,
   .phase_tick, .servo_tick, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);

/* File: tb/uic_backplane_model.sv */
// partner model: other units on the backplane claiming indices and sourcing the clocks
`timescale 1ns/100ps
module uic_backplane_model
   import uic_pkg::*;
(
   // clock
   input  wire logic        mclk,
   // index claims of the other units
   input  wire logic [15:0] peers,
   output logic [15:0]      peer_index_claim,
   // distributed clock wires
   input  wire logic        servo_clk_out,
   input  wire logic        servo_clk_oe,
   input  wire logic        phase_clk_out,
   input  wire logic        phase_clk_oe,
   output logic             servo_clk_in,
   output logic             phase_clk_in
);
   logic [3:0] div_ff = 4'h0;
   // peer source: phase every 4 cycles, servo every second phase, as the bench programs the unit
   always_ff @(posedge mclk) div_ff <= div_ff + 4'h1;
   assign peer_index_claim = peers;
   // a peer sources the clocks whenever this unit does not: one driver per wire
   assign phase_clk_in = phase_clk_oe ? phase_clk_out : div_ff[1];
   assign servo_clk_in = servo_clk_oe ? servo_clk_out : div_ff[2];
endmodule

/* File: tb/unit_index_clock_source_test.sv */
// testbench: switch index, duplicates, clock source choice, registers and interrupt of the unit clock block
`timescale 1ns/100ps
module unit_index_clock_source_test
   import uic_pkg::*;
;
   logic        mclk = 1'b0, rst = 1'b1, on_cpu_rack = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0;
   logic [3:0]  index_switch = 4'h0, io_asic_instance;
   logic [15:0] peers = 16'h0, peer_index_claim;
   logic [7:0]  reg_addr = 8'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic        servo_clk_in, phase_clk_in, servo_clk_out, servo_clk_oe, phase_clk_out, phase_clk_oe;
   logic        phase_tick, servo_tick, irq;
   logic [31:0] exp_q[$], msk_q[$];
   int          miscompares = 0, num_checks = 0;
   uic_unit_clock uut (.mclk, .rst, .index_switch, .on_cpu_rack, .peer_index_claim, .servo_clk_in, .phase_clk_in,
      .servo_clk_out, .servo_clk_oe, .phase_clk_out, .phase_clk_oe, .io_asic_instance, .phase_tick, .servo_tick,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
   uic_backplane_model u_bp (.mclk, .peers, .peer_index_claim, .servo_clk_out, .servo_clk_oe, .phase_clk_out,
      .phase_clk_oe, .servo_clk_in, .phase_clk_in);
   initial forever #12.5 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp, msk);
      num_checks++;
      if ((got & msk) !== (exp & msk)) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic lvl(input logic got, exp);
      chk({31'h0, got}, {31'h0, exp}, 32'h1);
   endtask
   task automatic wr(input logic [3:0] inst, off, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= {inst, off};
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] inst, off, input logic [31:0] e, m);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= {inst, off};
      exp_q.push_back(e);
      msk_q.push_back(m);
      @(posedge mclk);
      reg_rd <= 1'b0;
   endtask
   task automatic do_reset(input logic [3:0] sw, input logic [15:0] p, input logic strap);
      @(posedge mclk);
      rst <= 1'b1;
      index_switch <= sw;
      peers <= p;
      on_cpu_rack <= strap;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      repeat (20) @(posedge mclk);
   endtask
   function automatic logic [3:0] lo(input logic [15:0] v);
      lo = 4'h0;
      for (int i = 15; i >= 0; i--) if (v[i]) lo = 4'(i);
   endfunction
   function automatic logic [31:0] st(input logic [3:0] own, src, input logic [15:0] pr, input logic strap, warn);
      st = {17'h0, pr[own] ? CFG_ERR_DUP : CFG_ERR_NONE, src == own && !strap, src == own, warn, src, own};
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   // results of reads show one cycle after the strobe and are matched oldest first
   always @(posedge mclk) begin
      rd_q <= reg_rd;
      if (rd_q && exp_q.size() != 0) chk(reg_rdata, exp_q.pop_front(), msk_q.pop_front());
      else if (rd_q) begin
         miscompares++;
         $display("unexpected at %0t: read result with nothing expected", $time);
      end
   end
   initial begin
      repeat (100000) @(posedge mclk);
      miscompares++;
      final_report;
   end
   initial begin
      logic [3:0]  own, oth, src0;
      logic [15:0] pr;
      logic        strap;
      int          n, m;
      void'($urandom(32'h561a));
      for (int i = 0; i < 4; i++) begin
         own = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($urandom);
         oth = own + 4'h8;
         // odd runs put a second unit on our index
         pr = (16'($urandom) & ~(16'h1 << own)) | (i[0] ? (16'h1 << own) : 16'h0);
         src0 = lo(pr | (16'h1 << own));
         strap = i < 2;
         do_reset(own, pr, strap);
         // the switch moves after the latch and must be ignored
         index_switch <= own + 4'h1;
         rd(own, OFF_PHASE_RATE, {16'h0, RST_PHASE_RATE}, 32'hffffffff);
         rd(own, OFF_STATUS, st(own, src0, pr, strap, 1'b0), 32'hffffffff);
         chk({28'h0, io_asic_instance}, {28'h0, own}, 32'hf);
         wr(own, OFF_PHASE_RATE, 32'h4);
         wr(own, OFF_SERVO_DIV, 32'h1);
         wr(own, OFF_PHASE_MULT, 32'h0);
         wr(own, OFF_PHASE_DIV, {31'h0, i[0]});
         wr(oth, OFF_CTRL, {28'h1, oth});
         rd(oth, OFF_STATUS, 32'h0, 32'hffffffff);
         rd(own, 4'h8 | 4'($urandom), 32'h0, 32'hffffffff);
         // events from settling after reset: dup rise, missing-clock rise, source moved off 0
         rd(own, OFF_IRQ_STAT, {29'h0, src0 != 4'h0, src0 == own && !strap, pr[own]}, 32'h7);
         rd(own, OFF_STATUS, st(own, src0, pr, strap, i[0]), 32'hffffffff);
         lvl(phase_clk_oe, src0 == own);
         n = 0;
         m = 0;
         repeat (16) begin
            @(posedge mclk);
            n += int'(phase_tick);
            m += int'(servo_tick);
         end
         lvl(n == 4, 1'b1);
         lvl(m == 2, 1'b1);
         // masked events must not raise the interrupt line
         wr(own, OFF_IRQ_MASK, 32'h0);
         wr(own, OFF_CTRL, {28'h1, own});
         rd(own, OFF_CTRL, {28'h1, own}, 32'hffffffff);
         rd(own, OFF_STATUS, st(own, own, pr, strap, i[0]), 32'hffffffff);
         lvl(phase_clk_oe, 1'b1);
         lvl(irq, 1'b0);
         rd(own, OFF_IRQ_STAT, {29'h0, src0 != own, !strap && src0 != own, 1'b0}, 32'h7);
         wr(own, OFF_IRQ_MASK, 32'h7);
         wr(own, OFF_CTRL, {28'h1, oth});
         n = 0;
         while (irq !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
         end
         lvl(irq, 1'b1);
         if (irq !== 1'b1) final_report;
         lvl(phase_clk_oe, 1'b0);
         rd(own, OFF_IRQ_STAT, 32'h4, 32'h7);
         repeat (2) @(posedge mclk);
         lvl(irq, 1'b0);
      end
      repeat (2) @(posedge mclk);
      final_report;
   end
endmodule
